// ==== logic/spb_mac_end.sv ====
`timescale 1ns/10ps
`default_nettype none
module spb_mac_end #(
  parameter int SEGS = spb_pkg::SPB_SEGS,
  parameter int LANES = spb_pkg::SPB_LANES_4
) (
  input wire logic i_mclk,
  input wire logic i_rst_b,
  spb_if.mac bus,
  // lane mode, static out of reset
  input wire logic i_mode_four,
  // raw transceiver receive words, one per lane slot
  input wire logic [LANES-1:0][spb_pkg::SPB_XCVR_W-1:0] i_xcvr_rx_word,
  // receive lane clocks from the transceivers, treated as sampled levels
  input wire logic [spb_pkg::SPB_LANES_10-1:0] i_xcvr_rx_lane_clk,
  // decoded receive stream from the pcs, to be presented to the user
  input wire logic [SEGS-1:0][spb_pkg::SPB_SEG_W-1:0] i_pcs_rx_data,
  input wire logic [SEGS-1:0] i_pcs_rx_valid,
  input wire logic [SEGS-1:0] i_pcs_rx_first,
  input wire logic [SEGS-1:0] i_pcs_rx_last,
  input wire logic [SEGS-1:0] i_pcs_rx_bad,
  input wire logic [SEGS-1:0][spb_pkg::SPB_MTY_W-1:0] i_pcs_rx_empty,
  // captured transmit segments toward the pcs
  output logic [SEGS-1:0][spb_pkg::SPB_SEG_W-1:0] o_tx_data,
  output logic [SEGS-1:0] o_tx_valid,
  output logic [SEGS-1:0] o_tx_first,
  output logic [SEGS-1:0] o_tx_last,
  output logic [SEGS-1:0] o_tx_bad,
  output logic [SEGS-1:0][spb_pkg::SPB_MTY_W-1:0] o_tx_empty,
  output logic o_tx_gap_err,
  // lane multiplexer outputs
  output logic [LANES-1:0][spb_pkg::SPB_GRP_LO_W-1:0] o_lane_grp_lo,
  output logic [LANES-1:0][spb_pkg::SPB_GRP_HI_W-1:0] o_lane_grp_hi,
  output logic [spb_pkg::SPB_LANES_10-1:0] o_pcs_lane_clk_sel
);
  // ---------------------------------------------------------------
  // input synchronisers for mode and lane clock levels
  // ---------------------------------------------------------------
  logic mode_meta_reg;
  logic mode_reg;
  logic [spb_pkg::SPB_LANES_10-1:0] lclk_meta_reg;
  logic [spb_pkg::SPB_LANES_10-1:0] lclk_reg;

  // two stages on the mode strap
  always_ff @(posedge i_mclk or negedge i_rst_b)
  begin
    if (!i_rst_b)
    begin
      mode_meta_reg <= 1'b0;
      mode_reg <= 1'b0;
    end
    else
    begin
      mode_meta_reg <= i_mode_four;
      mode_reg <= mode_meta_reg;
    end
  end

  // two stages on the lane clock levels
  always_ff @(posedge i_mclk or negedge i_rst_b)
  begin
    if (!i_rst_b)
    begin
      lclk_meta_reg <= '0;
      lclk_reg <= '0;
    end
    else
    begin
      lclk_meta_reg <= i_xcvr_rx_lane_clk;
      lclk_reg <= lclk_meta_reg;
    end
  end

  // ---------------------------------------------------------------
  // transmit capture, one per segment
  // ---------------------------------------------------------------
  logic [SEGS-1:0] gap_seen;

  genvar s;
  generate
    for (s = 0; s < SEGS; s++)
    begin : g_tx
      // capture only on valid; end fields only on valid with last
      always_ff @(posedge i_mclk or negedge i_rst_b)
      begin
        if (!i_rst_b)
        begin
          o_tx_data[s] <= '0;
          o_tx_valid[s] <= 1'b0;
          o_tx_first[s] <= 1'b0;
          o_tx_last[s] <= 1'b0;
          o_tx_bad[s] <= 1'b0;
          o_tx_empty[s] <= spb_pkg::SPB_MTY_RST;
        end
        else
        begin
          o_tx_valid[s] <= bus.tx_seg_valid[s];
          if (bus.tx_seg_valid[s])
          begin
            o_tx_data[s] <= bus.tx_seg_data[s];
            o_tx_first[s] <= bus.tx_seg_first[s];
            o_tx_last[s] <= bus.tx_seg_last[s];
            if (bus.tx_seg_last[s])
            begin
              o_tx_bad[s] <= bus.tx_seg_bad[s];
              if (bus.tx_seg_bad[s])
                o_tx_empty[s] <= {bus.tx_seg_empty_count[s][spb_pkg::SPB_MTY_TOP],
                                  spb_pkg::SPB_MTY_LOW_ZERO};
              else
                o_tx_empty[s] <= bus.tx_seg_empty_count[s];
            end
            else
            begin
              o_tx_bad[s] <= 1'b0;
              o_tx_empty[s] <= spb_pkg::SPB_MTY_RST;
            end
          end
        end
      end
      // a valid segment above an idle one is a gap
      if (s == 0)
      begin : g_g0
        assign gap_seen[s] = 1'b0;
      end
      else
      begin : g_gn
        assign gap_seen[s] = bus.tx_seg_valid[s] & ~bus.tx_seg_valid[s-1];
      end
    end
  endgenerate

  // flags a user breach of segment ordering
  always_ff @(posedge i_mclk or negedge i_rst_b)
  begin
    if (!i_rst_b)
      o_tx_gap_err <= 1'b0;
    else
      o_tx_gap_err <= |gap_seen;
  end

  // ---------------------------------------------------------------
  // receive presentation, qualified by valid
  // ---------------------------------------------------------------
  generate
    for (s = 0; s < SEGS; s++)
    begin : g_rx
      // outside valid every qualified output reads zero
      always_ff @(posedge i_mclk or negedge i_rst_b)
      begin
        if (!i_rst_b)
        begin
          bus.rx_seg_data[s] <= '0;
          bus.rx_seg_valid[s] <= 1'b0;
          bus.rx_seg_first[s] <= 1'b0;
          bus.rx_seg_last[s] <= 1'b0;
          bus.rx_seg_bad[s] <= 1'b0;
          bus.rx_seg_empty_count[s] <= spb_pkg::SPB_MTY_RST;
        end
        else
        begin
          bus.rx_seg_valid[s] <= i_pcs_rx_valid[s];
          bus.rx_seg_data[s] <= i_pcs_rx_valid[s] ? i_pcs_rx_data[s] : '0;
          bus.rx_seg_first[s] <= i_pcs_rx_valid[s] & i_pcs_rx_first[s];
          bus.rx_seg_last[s] <= i_pcs_rx_valid[s] & i_pcs_rx_last[s];
          bus.rx_seg_bad[s] <= i_pcs_rx_valid[s] & i_pcs_rx_last[s]
                               & i_pcs_rx_bad[s];
          if (!(i_pcs_rx_valid[s] & i_pcs_rx_last[s]))
            bus.rx_seg_empty_count[s] <= spb_pkg::SPB_MTY_RST;
          else if (i_pcs_rx_bad[s])
            bus.rx_seg_empty_count[s] <= {i_pcs_rx_empty[s][spb_pkg::SPB_MTY_TOP],
                                          spb_pkg::SPB_MTY_LOW_ZERO};
          else
            bus.rx_seg_empty_count[s] <= i_pcs_rx_empty[s];
        end
      end
    end
  endgenerate

  // ---------------------------------------------------------------
  // lane multiplexer: 16/64 split, narrow in ten-lane mode
  // ---------------------------------------------------------------
  genvar l;
  generate
    for (l = 0; l < LANES; l++)
    begin : g_lane
      // ten-lane keeps the low 32 bits, upper bits of hi group zero
      always_ff @(posedge i_mclk or negedge i_rst_b)
      begin
        if (!i_rst_b)
        begin
          o_lane_grp_lo[l] <= '0;
          o_lane_grp_hi[l] <= '0;
        end
        else
        begin
          o_lane_grp_lo[l] <= i_xcvr_rx_word[l][spb_pkg::SPB_GRP_LO_POS +:
                                                spb_pkg::SPB_GRP_LO_W];
          if (mode_reg)
            o_lane_grp_hi[l] <= i_xcvr_rx_word[l][spb_pkg::SPB_GRP_HI_POS +:
                                                  spb_pkg::SPB_GRP_HI_W];
          else
            o_lane_grp_hi[l] <= {{(spb_pkg::SPB_XCVR_W - spb_pkg::SPB_NARROW_W){1'b0}},
                                 i_xcvr_rx_word[l][spb_pkg::SPB_GRP_HI_POS +:
                                 (spb_pkg::SPB_NARROW_W - spb_pkg::SPB_GRP_LO_W)]};
        end
      end
    end
  endgenerate

  // ---------------------------------------------------------------
  // rx lane clock selection; tx runs from i_mclk alone
  // ---------------------------------------------------------------
  genvar c;
  generate
    for (c = 0; c < spb_pkg::SPB_LANES_10; c++)
    begin : g_clk
      // four-lane mode drives each output lane c from the lane clock of lane c mod 4
      always_ff @(posedge i_mclk or negedge i_rst_b)
      begin
        if (!i_rst_b)
          o_pcs_lane_clk_sel[c] <= 1'b0;
        else if (mode_reg)
          o_pcs_lane_clk_sel[c] <= lclk_reg[c % spb_pkg::SPB_LANES_4];
        else
          o_pcs_lane_clk_sel[c] <= lclk_reg[c];
      end
    end
  endgenerate
endmodule
`default_nettype wire

// ==== logic/spb_pkg.sv ====
`default_nettype none
package spb_pkg;
  // ---------------------------------------------------------------
  // bus geometry
  // ---------------------------------------------------------------
  localparam int SPB_SEGS = 4;
  localparam int SPB_SEG_W = 128;
  localparam int SPB_BUS_W = 512;
  localparam int SPB_MTY_W = 4;
  localparam int SPB_BYTES = 16;
  // ---------------------------------------------------------------
  // transceiver lane geometry
  // ---------------------------------------------------------------
  localparam int SPB_XCVR_W = 80;
  localparam int SPB_NARROW_W = 32;
  localparam int SPB_GRP_LO_W = 16;
  localparam int SPB_GRP_HI_W = 64;
  localparam int SPB_GRP_LO_POS = 0;
  localparam int SPB_GRP_HI_POS = 16;
  localparam int SPB_LANES_10 = 10;
  localparam int SPB_LANES_4 = 4;
  // ---------------------------------------------------------------
  // reset values and field positions
  // ---------------------------------------------------------------
  localparam logic [3:0] SPB_MTY_RST = 4'h0;
  localparam logic [2:0] SPB_MTY_LOW_ZERO = 3'h0;
  localparam int SPB_MTY_TOP = 3;
  localparam int SPB_FIRST_BYTE_HI = 127;
  // lane mode
  typedef enum logic {SPB_MODE_TEN, SPB_MODE_FOUR} spb_mode_t;
endpackage
`default_nettype wire

// ==== logic/spb_if.sv ====
`timescale 1ns/10ps
`default_nettype none
// segmented packet bus between user logic and the mac end
interface spb_if;
  logic [spb_pkg::SPB_SEGS-1:0][spb_pkg::SPB_SEG_W-1:0] tx_seg_data;
  logic [spb_pkg::SPB_SEGS-1:0] tx_seg_valid;
  logic [spb_pkg::SPB_SEGS-1:0] tx_seg_first;
  logic [spb_pkg::SPB_SEGS-1:0] tx_seg_last;
  logic [spb_pkg::SPB_SEGS-1:0] tx_seg_bad;
  logic [spb_pkg::SPB_SEGS-1:0][spb_pkg::SPB_MTY_W-1:0] tx_seg_empty_count;
  logic [spb_pkg::SPB_SEGS-1:0][spb_pkg::SPB_SEG_W-1:0] rx_seg_data;
  logic [spb_pkg::SPB_SEGS-1:0] rx_seg_valid;
  logic [spb_pkg::SPB_SEGS-1:0] rx_seg_first;
  logic [spb_pkg::SPB_SEGS-1:0] rx_seg_last;
  logic [spb_pkg::SPB_SEGS-1:0] rx_seg_bad;
  logic [spb_pkg::SPB_SEGS-1:0][spb_pkg::SPB_MTY_W-1:0] rx_seg_empty_count;
  // mac end: takes tx, drives rx
  modport mac (
    input tx_seg_data, tx_seg_valid, tx_seg_first, tx_seg_last, tx_seg_bad,
    tx_seg_empty_count,
    output rx_seg_data, rx_seg_valid, rx_seg_first, rx_seg_last, rx_seg_bad,
    rx_seg_empty_count
  );
  // user end: drives tx, takes rx
  modport user (
    output tx_seg_data, tx_seg_valid, tx_seg_first, tx_seg_last, tx_seg_bad,
    tx_seg_empty_count,
    input rx_seg_data, rx_seg_valid, rx_seg_first, rx_seg_last, rx_seg_bad,
    rx_seg_empty_count
  );
endinterface
`default_nettype wire

// ==== logic/spb_user_end.sv ====
`timescale 1ns/10ps
`default_nettype none
module spb_user_end #(
  parameter int SEGS = spb_pkg::SPB_SEGS
) (
  input wire logic i_mclk,
  input wire logic i_rst_b,
  spb_if.user bus,
  // one segment-wide transfer request per segment
  input wire logic [SEGS-1:0][spb_pkg::SPB_SEG_W-1:0] i_data,
  input wire logic [SEGS-1:0] i_valid,
  input wire logic [SEGS-1:0] i_first,
  input wire logic [SEGS-1:0] i_last,
  input wire logic [SEGS-1:0] i_bad,
  input wire logic [SEGS-1:0][spb_pkg::SPB_MTY_W-1:0] i_empty,
  // received segments, taken every cycle
  output logic [SEGS-1:0][spb_pkg::SPB_SEG_W-1:0] o_data,
  output logic [SEGS-1:0] o_valid,
  output logic [SEGS-1:0] o_first,
  output logic [SEGS-1:0] o_last,
  output logic [SEGS-1:0] o_bad,
  output logic [SEGS-1:0][spb_pkg::SPB_MTY_W-1:0] o_empty
);
  // ---------------------------------------------------------------
  // transmit drive: gap-free valid, clean end fields
  // ---------------------------------------------------------------
  logic [SEGS-1:0] run;

  genvar s;
  generate
    for (s = 0; s < SEGS; s++)
    begin : g_tx
      // a segment may go only if every lower one goes
      if (s == 0)
      begin : g_r0
        assign run[s] = i_valid[s];
      end
      else
      begin : g_rn
        assign run[s] = i_valid[s] & run[s-1];
      end
      always_ff @(posedge i_mclk or negedge i_rst_b)
      begin
        if (!i_rst_b)
        begin
          bus.tx_seg_data[s] <= '0;
          bus.tx_seg_valid[s] <= 1'b0;
          bus.tx_seg_first[s] <= 1'b0;
          bus.tx_seg_last[s] <= 1'b0;
          bus.tx_seg_bad[s] <= 1'b0;
          bus.tx_seg_empty_count[s] <= spb_pkg::SPB_MTY_RST;
        end
        else
        begin
          bus.tx_seg_valid[s] <= run[s];
          bus.tx_seg_data[s] <= i_data[s];
          bus.tx_seg_first[s] <= run[s] & i_first[s];
          bus.tx_seg_last[s] <= run[s] & i_last[s];
          bus.tx_seg_bad[s] <= run[s] & i_last[s] & i_bad[s];
          bus.tx_seg_empty_count[s] <= (run[s] & i_last[s]) ? i_empty[s]
                                       : spb_pkg::SPB_MTY_RST;
        end
      end
      // receive taken unconditionally, no stall
      always_ff @(posedge i_mclk or negedge i_rst_b)
      begin
        if (!i_rst_b)
        begin
          o_data[s] <= '0;
          o_valid[s] <= 1'b0;
          o_first[s] <= 1'b0;
          o_last[s] <= 1'b0;
          o_bad[s] <= 1'b0;
          o_empty[s] <= spb_pkg::SPB_MTY_RST;
        end
        else
        begin
          o_valid[s] <= bus.rx_seg_valid[s];
          o_data[s] <= bus.rx_seg_data[s];
          o_first[s] <= bus.rx_seg_valid[s] & bus.rx_seg_first[s];
          o_last[s] <= bus.rx_seg_valid[s] & bus.rx_seg_last[s];
          o_bad[s] <= bus.rx_seg_valid[s] & bus.rx_seg_last[s] & bus.rx_seg_bad[s];
          o_empty[s] <= bus.rx_seg_empty_count[s];
        end
      end
    end
  endgenerate
endmodule
`default_nettype wire

// ==== test/spb_checker.sv ====
`timescale 1ns/10ps
`default_nettype none
module spb_checker (
  input wire logic i_mclk,
  input wire logic i_rst_b,
  input wire logic [3:0] tx_seg_valid,
  input wire logic [3:0] tx_seg_last,
  input wire logic [3:0] tx_seg_bad,
  input wire logic [3:0][127:0] rx_seg_data,
  input wire logic [3:0] rx_seg_valid,
  input wire logic [3:0] rx_seg_first,
  input wire logic [3:0] rx_seg_last,
  input wire logic [3:0] rx_seg_bad,
  input wire logic [3:0][3:0] rx_seg_empty_count
);
  default clocking cb @(posedge i_mclk);
  endclocking
  default disable iff (!i_rst_b);
  // ---------------------------------------------------------------
  // whole-bus relations
  // ---------------------------------------------------------------
  property p_rel;
    $rose(i_rst_b) |-> rx_seg_valid == 4'h0 && tx_seg_valid == 4'h0;
  endproperty
  a_rel: assert property (p_rel) else $error("bus active at reset release");
  property p_rx_flags;
    ((rx_seg_first | rx_seg_last) & ~rx_seg_valid) == 4'h0;
  endproperty
  a_rx_flags: assert property (p_rx_flags) else $error("rx flag outside valid");
  property p_rx_bad;
    (rx_seg_bad & ~(rx_seg_valid & rx_seg_last)) == 4'h0;
  endproperty
  a_rx_bad: assert property (p_rx_bad) else $error("rx bad outside end");
  property p_tx_gap;
    tx_seg_valid inside {4'h0, 4'h1, 4'h3, 4'h7, 4'hF};
  endproperty
  a_tx_gap: assert property (p_tx_gap) else $error("tx segment gap");
  property p_tx_bad;
    (tx_seg_bad & ~(tx_seg_valid & tx_seg_last)) == 4'h0;
  endproperty
  a_tx_bad: assert property (p_tx_bad) else $error("tx bad outside end");
  // ---------------------------------------------------------------
  // per-segment relations
  // ---------------------------------------------------------------
  for (genvar s = 0; s < 4; s++)
  begin : g_seg
    property p_rx_data;
      !rx_seg_valid[s] |-> rx_seg_data[s] == 128'h0;
    endproperty
    a_rx_data: assert property (p_rx_data) else $error("rx data outside valid");
    property p_rx_empty;
      !(rx_seg_valid[s] && rx_seg_last[s]) |-> rx_seg_empty_count[s] == 4'h0;
    endproperty
    a_rx_empty: assert property (p_rx_empty) else $error("rx empty outside end");
    property p_rx_bad_empty;
      rx_seg_valid[s] && rx_seg_bad[s] |-> rx_seg_empty_count[s][2:0] == 3'h0;
    endproperty
    a_rx_bad_empty: assert property (p_rx_bad_empty) else $error("rx empty low bits");
  end
endmodule
`default_nettype wire

// ==== test/tb_top.sv ====
`timescale 1ns/10ps
`default_nettype none
module tb_top;
  logic mclk = 1'b0;
  logic rst_b = 1'b0;
  logic mode = 1'b1;
  logic [3:0][127:0] u_d = 512'h0, p_d = 512'h0, t_d, r_d;
  logic [3:0] u_v = 4'h0, u_f = 4'h0, u_l = 4'h0, u_b = 4'h0;
  logic [3:0] p_v = 4'h0, p_f = 4'h0, p_l = 4'h0, p_b = 4'h0;
  logic [3:0] t_v, t_f, t_l, t_b, r_v, r_f, r_l, r_b;
  logic [3:0][3:0] u_e = 16'h0, p_e = 16'h0, t_e, r_e;
  logic [3:0][79:0] w = 320'h0;
  logic [3:0][15:0] glo;
  logic [3:0][63:0] ghi;
  logic [9:0] lck = 10'h0, csel;
  logic gap;
  int n_fail = 0;
  int checks = 0;
  // ---------------------------------------------------------------
  // clock, both ends and checker
  // ---------------------------------------------------------------
  always #12.5 mclk = ~mclk;
  spb_if bus_if ();
  spb_mac_end spb_mac_end_inst (.i_mclk(mclk), .i_rst_b(rst_b), .bus(bus_if.mac),
    .i_mode_four(mode), .i_xcvr_rx_word(w), .i_xcvr_rx_lane_clk(lck), .i_pcs_rx_data(p_d),
    .i_pcs_rx_valid(p_v), .i_pcs_rx_first(p_f), .i_pcs_rx_last(p_l), .i_pcs_rx_bad(p_b),
    .i_pcs_rx_empty(p_e), .o_tx_data(t_d), .o_tx_valid(t_v), .o_tx_first(t_f),
    .o_tx_last(t_l), .o_tx_bad(t_b), .o_tx_empty(t_e), .o_tx_gap_err(gap),
    .o_lane_grp_lo(glo), .o_lane_grp_hi(ghi), .o_pcs_lane_clk_sel(csel));
  spb_user_end spb_user_end_inst (.i_mclk(mclk), .i_rst_b(rst_b), .bus(bus_if.user),
    .i_data(u_d), .i_valid(u_v), .i_first(u_f), .i_last(u_l), .i_bad(u_b), .i_empty(u_e),
    .o_data(r_d), .o_valid(r_v), .o_first(r_f), .o_last(r_l), .o_bad(r_b), .o_empty(r_e));
  spb_checker spb_checker_inst (.i_mclk(mclk), .i_rst_b(rst_b),
    .tx_seg_valid(bus_if.tx_seg_valid), .tx_seg_last(bus_if.tx_seg_last),
    .tx_seg_bad(bus_if.tx_seg_bad), .rx_seg_data(bus_if.rx_seg_data),
    .rx_seg_valid(bus_if.rx_seg_valid), .rx_seg_first(bus_if.rx_seg_first),
    .rx_seg_last(bus_if.rx_seg_last), .rx_seg_bad(bus_if.rx_seg_bad),
    .rx_seg_empty_count(bus_if.rx_seg_empty_count));
  // ---------------------------------------------------------------
  // shared helpers
  // ---------------------------------------------------------------
  task automatic step(input int n);
    repeat (n) @(posedge mclk);
    #1;
  endtask
  task automatic chk(input string nm, input logic [511:0] exp, input logic [511:0] got);
    checks++;
    if (got !== exp)
    begin
      n_fail++;
      $display("[FAIL] %s expected %0h seen %0h", nm, exp, got);
    end
  endtask
  // one user request, then two edges to reach the mac outputs
  task automatic send();
    step(1);
    {u_v, u_f, u_l, u_b} = 16'h0;
    step(1);
  endtask
  task automatic tx_full();
    for (int s = 0; s < 4; s++)
      u_d[s] = {4{32'hC0DE_0000 + 32'(s)}};
    {u_v, u_f, u_l} = 12'hF18;
    u_e = 16'h5000;
    send();
    chk("tx data", u_d, t_d);
    chk("tx ctl", 12'hF18, {t_v, t_f, t_l});
    chk("tx empty", 16'h5000, t_e);
    $display("tx_full done");
  endtask
  task automatic tx_ignore();
    u_d = ~u_d;
    {u_f, u_l} = 8'hFF;
    u_e = 16'hFFFF;
    step(2);
    chk("tx held data", ~u_d, t_d);
    chk("tx held ctl", 12'h018, {t_v, t_f, t_l});
    $display("tx_ignore done");
  endtask
  task automatic tx_end();
    {u_v, u_f, u_l, u_b} = 16'h7131;
    u_e = 16'h3FFF;
    send();
    // idle seg 3 keeps the last flag it captured in tx_full
    chk("tx end ctl", 16'h71B1, {t_v, t_f, t_l, t_b});
    chk("tx end empty", 12'h0F8, t_e[2:0]);
    $display("tx_end done");
  endtask
  task automatic tx_gap();
    u_v = 4'hD;
    send();
    chk("tx gap valid", 4'h1, t_v);
    chk("tx gap flag", 1'b0, gap);
    $display("tx_gap done");
  endtask
  task automatic rx_pkt();
    p_d = ~u_d;
    {p_v, p_f, p_l, p_b} = 16'hF1A3;
    p_e = 16'h5FF3;
    step(1);
    {p_v, p_f, p_l, p_b} = 16'h0;
    step(1);
    chk("rx data", ~u_d, r_d);
    chk("rx ctl", 16'hF1A2, {r_v, r_f, r_l, r_b});
    chk("rx empty", 16'h5080, r_e);
    $display("rx_pkt done");
  endtask
  task automatic rx_idle();
    {p_f, p_l, p_b} = 12'hFFF;
    p_e = 16'hFFFF;
    step(2);
    chk("rx idle data", 512'h0, r_d);
    chk("rx idle ctl", 32'h0, {r_v, r_f, r_l, r_b, r_e});
    {p_f, p_l, p_b} = 12'h0;
    p_e = 16'h0;
    $display("rx_idle done");
  endtask
  task automatic lane_mux();
    logic [9:0] e;
    for (int s = 0; s < 4; s++)
      w[s] = {16'hBEEF, 32'h1234_5678 + 32'(s), 32'h9ABC_DEF0 - 32'(s)};
    lck = 10'h2B5;
    step(4);
    for (int c = 0; c < 10; c++)
      e[c] = lck[c % 4];
    for (int s = 0; s < 4; s++)
    begin
      chk("grp lo", w[s][15:0], glo[s]);
      chk("grp hi four", w[s][79:16], ghi[s]);
    end
    chk("clk sel four", e, csel);
    // ten-lane mode is only changed under reset
    rst_b = 1'b0;
    mode = 1'b0;
    step(2);
    rst_b = 1'b1;
    step(4);
    for (int s = 0; s < 4; s++)
      chk("grp hi ten", {48'h0, w[s][31:16]}, ghi[s]);
    chk("clk sel ten", lck, csel);
    $display("lane_mux done");
  endtask
  task automatic test_done();
    $display("checks %0d n_fail %0d", checks, n_fail);
    if (n_fail == 0 && checks > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask
  // ---------------------------------------------------------------
  // sequence and watchdog
  // ---------------------------------------------------------------
  initial
  begin
    repeat (20) @(posedge mclk);
    #1;
    rst_b = 1'b1;
    step(1);
    tx_full();
    tx_ignore();
    tx_end();
    tx_gap();
    rx_pkt();
    rx_idle();
    lane_mux();
    test_done();
  end
  // tests need about 45 cycles; cut off at 5000
  initial
  begin
    #(25 * 5000);
    n_fail++;
    test_done();
  end
endmodule
`default_nettype wire
